// ### hls_pkg.sv
// Constants, types and helper functions of the host link serial port.
// Overview of operation
// [R1] Port 1 is an RS-232C line only, half or full duplex from its configuration.
// [R2] Port 2 selects RS-232C or RS-422; RS-422 always runs full duplex.
// [R3] Start-stop framing with one or two stop bits from the port configuration.
// [R4] Bit rate per port is one of 1200, 2400, 4800, 9600 or 19200 bps.
// [R5] Characters carry seven or eight data bits, chosen per port.
// [R6] Even, odd or no parity is sent and checked as configured.
// [R7] A frame check byte is accumulated for sent and for received characters.
// [R8] Optional Xon/Xoff flow control pauses and resumes the transmitter per port.
// [R9] Each port keeps its own one-word count of communication errors.
// [R10] On Xoff the character in progress completes; output then waits for Xon.
package hls_pkg;
    localparam int HLS_CLK_HZ = 250000000;
    localparam int HLS_OVS = 16;
    localparam int HLS_ADDR_W = 8;
    localparam logic [7:0] HLS_CFG0 = 8'h00;
    localparam logic [7:0] HLS_CFG1 = 8'h04;
    localparam logic [7:0] HLS_TX0 = 8'h08;
    localparam logic [7:0] HLS_TX1 = 8'h0c;
    localparam logic [7:0] HLS_RX0 = 8'h10;
    localparam logic [7:0] HLS_RX1 = 8'h14;
    localparam logic [7:0] HLS_STAT = 8'h18;
    localparam logic [7:0] HLS_MASK = 8'h1c;
    localparam logic [7:0] HLS_ERR0 = 8'h20;
    localparam logic [7:0] HLS_ERR1 = 8'h24;
    localparam logic [7:0] HLS_FCHK0 = 8'h28;
    localparam logic [7:0] HLS_FCHK1 = 8'h2c;
    localparam logic [7:0] HLS_LIVE = 8'h30;
    localparam int HLS_CFG_W = 10;
    localparam int HLS_CFG_FDX = 0;
    localparam int HLS_CFG_STOP2 = 1;
    localparam int HLS_CFG_BAUD = 2;
    localparam int HLS_CFG_DATA8 = 5;
    localparam int HLS_CFG_PAR = 6;
    localparam int HLS_CFG_XON = 8;
    localparam int HLS_CFG_RS422 = 9;
    localparam logic [9:0] HLS_CFG_RESET = 10'h04c;
    localparam logic [9:0] HLS_CFG_MASK1 = 10'h1ff;
    localparam logic [9:0] HLS_CFG_MASK2 = 10'h3ff;
    localparam logic [1:0] HLS_PAR_EVEN = 2'h1;
    localparam logic [1:0] HLS_PAR_ODD = 2'h2;
    localparam int HLS_EV_W = 5;
    localparam int HLS_EV_RX = 0;
    localparam int HLS_EV_TXDONE = 1;
    localparam int HLS_EV_PAR = 2;
    localparam int HLS_EV_FRM = 3;
    localparam int HLS_EV_OVR = 4;
    localparam int HLS_STAT_W = 10;
    localparam int HLS_LIVE_W = 8;
    localparam logic [7:0] HLS_XON = 8'h11;
    localparam logic [7:0] HLS_XOFF = 8'h13;
    localparam logic [15:0] HLS_ERR_MAX = 16'hffff;

    typedef enum logic [1:0] {HLS_TX_IDLE = 2'b01, HLS_TX_SHIFT = 2'b10} hls_tx_state_type;
    typedef enum logic [2:0]
    {
        HLS_RX_IDLE = 3'b001,
        HLS_RX_START = 3'b010,
        HLS_RX_BITS = 3'b100
    } hls_rx_state_type;

    function automatic int hls_rate(input logic [2:0] sel);
        case (sel)
            3'h0: return 1200;
            3'h1: return 2400;
            3'h2: return 4800;
            3'h3: return 9600;
            default: return 19200;
        endcase
    endfunction : hls_rate

    // Parity bit over the active data bits; zero when parity is off.
    function automatic logic hls_par_bit(input logic [7:0] d, input logic data8,
                                         input logic [1:0] par);
        logic x;
        x = ^{d[7] & data8, d[6:0]};
        if (par == HLS_PAR_EVEN)
            return x;
        else if (par == HLS_PAR_ODD)
            return ~x;
        else
            return 1'b0;
    endfunction : hls_par_bit

    function automatic logic hls_par_on(input logic [1:0] par);
        return (par == HLS_PAR_EVEN) || (par == HLS_PAR_ODD);
    endfunction : hls_par_on

    // Bits of a character after the start bit: data, parity and stop bits.
    function automatic logic [3:0] hls_frame_len(input logic data8, input logic [1:0] par,
                                                 input logic stop2);
        return 4'h7 + {3'h0, data8} + {3'h0, hls_par_on(par)} + {3'h0, stop2} + 4'h1;
    endfunction : hls_frame_len
endpackage : hls_pkg

// ### hls_serial_rx.sv
// Receiver of one start-stop serial port with sixteen-fold oversampling.
`timescale 1ns/10ps
module hls_serial_rx
    import hls_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rxd,
    input wire logic tick,
    input wire logic enable,
    input wire logic data8,
    input wire logic [1:0] par,
    output logic valid,
    output logic [7:0] data,
    output logic par_err,
    output logic frm_err,
    output logic busy
);
    hls_rx_state_type state;
    logic [3:0] sub;
    logic [3:0] left;
    logic [9:0] shift;
    logic [9:0] next_shift;
    logic [9:0] bits;
    logic [3:0] nbits;
    logic pbit;

    // Only the first stop bit is checked, so one-stop and two-stop senders both pass.
    assign nbits = hls_frame_len(data8, par, 1'b0);
    assign next_shift = {rxd, shift[9:1]};
    assign bits = next_shift >> (4'ha - nbits);
    assign pbit = data8 ? bits[8] : bits[7];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= HLS_RX_IDLE;
            sub <= 4'h0;
            left <= 4'h0;
            shift <= 10'h000;
        end
        else
        begin
            case (state)
                HLS_RX_IDLE:
                begin
                    sub <= 4'h0;
                    if (enable && !rxd)
                        state <= HLS_RX_START;
                end
                HLS_RX_START:
                begin
                    if (tick)
                    begin
                        sub <= sub + 4'h1;
                        if (sub == 4'h7)
                        begin
                            sub <= 4'h0;
                            left <= nbits;
                            state <= rxd ? HLS_RX_IDLE : HLS_RX_BITS;
                        end
                    end
                end
                HLS_RX_BITS:
                begin
                    if (tick)
                    begin
                        sub <= sub + 4'h1;
                        if (sub == 4'hf)
                        begin
                            shift <= next_shift;
                            left <= left - 4'h1;
                            if (left == 4'h1)
                                state <= HLS_RX_IDLE;
                        end
                    end
                end
                default: state <= HLS_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            valid <= 1'b0;
            data <= 8'h00;
            par_err <= 1'b0;
            frm_err <= 1'b0;
        end
        else
        begin
            valid <= 1'b0;
            par_err <= 1'b0;
            frm_err <= 1'b0;
            if (state == HLS_RX_BITS && tick && sub == 4'hf && left == 4'h1)
            begin
                valid <= 1'b1;
                data <= {bits[7] & data8, bits[6:0]}; // [R5]
                par_err <= hls_par_on(par) && (pbit != hls_par_bit(bits[7:0], data8, par)); // [R6]
                frm_err <= !rxd; // [R3]
            end
        end
    end

    assign busy = (state != HLS_RX_IDLE);
endmodule : hls_serial_rx

// ### hls_host_link_serial_port.sv
// Two-port start-stop serial unit with an APB register file.
`timescale 1ns/10ps
module hls_host_link_serial_port
    import hls_pkg::*;
#(
    parameter int CLK_HZ = HLS_CLK_HZ
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [HLS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd_p1,
    input wire logic rxd_p2,
    output logic txd_p1,
    output logic txd_p2,
    output logic full_duplex_p1,
    output logic full_duplex_p2,
    output logic line_rs422_p2,
    output logic irq
);
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic [31:0] rd_val;
    logic [1:0] rxd_in;
    logic [1:0] txd_q;
    logic [1:0] fdx_q;
    logic [HLS_CFG_W-1:0] cfg [2];
    logic [7:0] rx_data [2];
    logic [15:0] err_cnt [2];
    logic [7:0] fchk_tx [2];
    logic [7:0] fchk_rx [2];
    logic [HLS_LIVE_W-1:0] live [2];
    logic [HLS_STAT_W-1:0] stat;
    logic [HLS_STAT_W-1:0] mask;
    logic [HLS_STAT_W-1:0] ev;
    logic [HLS_STAT_W-1:0] next_stat;

    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign rxd_in = {rxd_p2, rxd_p1};
    assign txd_p1 = txd_q[0];
    assign txd_p2 = txd_q[1];
    assign full_duplex_p1 = fdx_q[0];
    assign full_duplex_p2 = fdx_q[1];

    // Every access takes exactly one wait state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && penable && !pready)
                prdata <= pwrite ? 32'h00000000 : rd_val;
        end
    end

    always_comb
    begin
        mapped = 1'b1;
        rd_val = 32'h00000000;
        if (paddr == HLS_CFG0)
            rd_val = {22'h000000, cfg[0]};
        else if (paddr == HLS_CFG1)
            rd_val = {22'h000000, cfg[1]};
        else if (paddr == HLS_TX0 || paddr == HLS_TX1)
            rd_val = 32'h00000000;
        else if (paddr == HLS_RX0)
            rd_val = {24'h000000, rx_data[0]};
        else if (paddr == HLS_RX1)
            rd_val = {24'h000000, rx_data[1]};
        else if (paddr == HLS_STAT)
            rd_val = {22'h000000, stat};
        else if (paddr == HLS_MASK)
            rd_val = {22'h000000, mask};
        else if (paddr == HLS_ERR0)
            rd_val = {16'h0000, err_cnt[0]};
        else if (paddr == HLS_ERR1)
            rd_val = {16'h0000, err_cnt[1]};
        else if (paddr == HLS_FCHK0)
            rd_val = {16'h0000, fchk_rx[0], fchk_tx[0]};
        else if (paddr == HLS_FCHK1)
            rd_val = {16'h0000, fchk_rx[1], fchk_tx[1]};
        else if (paddr == HLS_LIVE)
            rd_val = {16'h0000, live[1], live[0]};
        else
            mapped = 1'b0;
    end

    // Sticky events: a new event in the clearing cycle stays set.
    assign next_stat = (stat & ~((wr && paddr == HLS_STAT) ? pwdata[HLS_STAT_W-1:0] : '0)) | ev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat <= '0;
            mask <= '0;
            irq <= 1'b0;
        end
        else
        begin
            stat <= next_stat;
            if (wr && paddr == HLS_MASK)
                mask <= pwdata[HLS_STAT_W-1:0];
            irq <= |(next_stat & mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            line_rs422_p2 <= 1'b0;
        else
            line_rs422_p2 <= cfg[1][HLS_CFG_RS422]; // [R2]
    end

    for (genvar g = 0; g < 2; g++)
    begin : gen_port
        localparam logic [7:0] OFF_CFG = (g == 0) ? HLS_CFG0 : HLS_CFG1;
        localparam logic [7:0] OFF_TX = (g == 0) ? HLS_TX0 : HLS_TX1;
        localparam logic [7:0] OFF_RX = (g == 0) ? HLS_RX0 : HLS_RX1;
        localparam logic [7:0] OFF_ERR = (g == 0) ? HLS_ERR0 : HLS_ERR1;
        localparam logic [7:0] OFF_FCHK = (g == 0) ? HLS_FCHK0 : HLS_FCHK1;
        localparam logic [9:0] CFG_MASK = (g == 0) ? HLS_CFG_MASK1 : HLS_CFG_MASK2;
        hls_tx_state_type tx_state;
        logic fdx;
        logic data8;
        logic stop2;
        logic xon_en;
        logic [1:0] par;
        logic [15:0] div_cnt;
        logic [15:0] div_load;
        logic tick;
        logic [7:0] tx_hold;
        logic tx_full;
        logic tx_load;
        logic tx_done;
        logic [3:0] tx_sub;
        logic [3:0] tx_left;
        logic [10:0] tx_shift;
        logic [10:0] frame;
        logic paused;
        logic rx_busy;
        logic rx_valid;
        logic [7:0] rx_char;
        logic rx_perr;
        logic rx_ferr;
        logic rx_full;
        logic rx_flow;
        logic rx_store;
        logic rx_ovr;
        logic err_inc;

        // RS-422 forces full duplex; port 1 cannot select it.
        assign fdx = cfg[g][HLS_CFG_FDX] | cfg[g][HLS_CFG_RS422]; // [R1] [R2]
        assign data8 = cfg[g][HLS_CFG_DATA8];
        assign stop2 = cfg[g][HLS_CFG_STOP2];
        assign xon_en = cfg[g][HLS_CFG_XON];
        assign par = cfg[g][HLS_CFG_PAR +: 2];
        assign div_load = 16'(CLK_HZ / (HLS_OVS * hls_rate(cfg[g][HLS_CFG_BAUD +: 3])) - 1); // [R4]
        assign tick = (div_cnt == 16'h0000);

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                cfg[g] <= HLS_CFG_RESET;
                fdx_q[g] <= 1'b0;
            end
            else
            begin
                if (wr && paddr == OFF_CFG)
                    cfg[g] <= pwdata[HLS_CFG_W-1:0] & CFG_MASK;
                fdx_q[g] <= fdx;
            end
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                div_cnt <= 16'h0000;
            else if (tick)
                div_cnt <= div_load; // [R4]
            else
                div_cnt <= div_cnt - 16'h0001;
        end

        // Half duplex: no new character starts while one is being received.
        assign tx_load = (tx_state == HLS_TX_IDLE) && tx_full && !paused && tick
            && (fdx || !rx_busy); // [R1] [R10]
        assign tx_done = (tx_state == HLS_TX_SHIFT) && tick && tx_sub == 4'hf
            && tx_left == 4'h0;
        assign frame = data8
            ? {2'h3, hls_par_bit(tx_hold, data8, par), tx_hold}
            : {3'h7, hls_par_bit(tx_hold, data8, par), tx_hold[6:0]};

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                tx_hold <= 8'h00;
                tx_full <= 1'b0;
            end
            else if (wr && paddr == OFF_TX && !tx_full)
            begin
                tx_hold <= pwdata[7:0];
                tx_full <= 1'b1;
            end
            else if (tx_load)
                tx_full <= 1'b0;
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                tx_state <= HLS_TX_IDLE;
                txd_q[g] <= 1'b1;
                tx_sub <= 4'h0;
                tx_left <= 4'h0;
                tx_shift <= '1;
            end
            else
            begin
                case (tx_state)
                    HLS_TX_IDLE:
                    begin
                        txd_q[g] <= 1'b1;
                        if (tx_load)
                        begin
                            txd_q[g] <= 1'b0; // [R3]
                            tx_sub <= 4'h0;
                            tx_left <= hls_frame_len(data8, par, stop2); // [R3] [R5]
                            // Without parity the parity slot is dropped.
                            tx_shift <= hls_par_on(par) ? frame
                                : (data8 ? {frame[10:9], 1'b1, frame[7:0]}
                                : {frame[10:8], 1'b1, frame[6:0]}); // [R6]
                            tx_state <= HLS_TX_SHIFT;
                        end
                    end
                    HLS_TX_SHIFT:
                    begin
                        if (tick)
                        begin
                            tx_sub <= tx_sub + 4'h1;
                            if (tx_sub == 4'hf)
                            begin
                                if (tx_left == 4'h0)
                                    tx_state <= HLS_TX_IDLE;
                                else
                                begin
                                    txd_q[g] <= tx_shift[0];
                                    tx_shift <= {1'b1, tx_shift[10:1]};
                                    tx_left <= tx_left - 4'h1;
                                end
                            end
                        end
                    end
                    default: tx_state <= HLS_TX_IDLE;
                endcase
            end
        end

        hls_serial_rx u_rx
        (
            .pclk(pclk),
            .presetn(presetn),
            .rxd(rxd_in[g]),
            .tick(tick),
            .enable(fdx || tx_state == HLS_TX_IDLE), // [R1]
            .data8(data8),
            .par(par),
            .valid(rx_valid),
            .data(rx_char),
            .par_err(rx_perr),
            .frm_err(rx_ferr),
            .busy(rx_busy)
        );

        assign rx_flow = rx_valid && xon_en && (rx_char == HLS_XON || rx_char == HLS_XOFF);
        assign rx_store = rx_valid && !rx_flow;
        assign rx_ovr = rx_store && rx_full && !(rd && paddr == OFF_RX);

        // Flow control characters are consumed here and never reach software.
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                paused <= 1'b0;
            else if (!xon_en)
                paused <= 1'b0;
            else if (rx_flow)
                paused <= (rx_char == HLS_XOFF); // [R8] [R10]
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                rx_data[g] <= 8'h00;
                rx_full <= 1'b0;
            end
            else if (rx_store && !rx_ovr)
            begin
                rx_data[g] <= rx_char;
                rx_full <= 1'b1;
            end
            else if (rd && paddr == OFF_RX)
                rx_full <= 1'b0;
        end

        // Frame check bytes are running XORs; any write restarts both.
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                fchk_tx[g] <= 8'h00;
                fchk_rx[g] <= 8'h00;
            end
            else
            begin
                if (wr && paddr == OFF_FCHK)
                    fchk_tx[g] <= tx_load ? tx_hold : 8'h00;
                else if (tx_load)
                    fchk_tx[g] <= fchk_tx[g] ^ tx_hold; // [R7]
                if (wr && paddr == OFF_FCHK)
                    fchk_rx[g] <= rx_store ? rx_char : 8'h00;
                else if (rx_store)
                    fchk_rx[g] <= fchk_rx[g] ^ rx_char; // [R7]
            end
        end

        assign err_inc = rx_perr || rx_ferr || rx_ovr;

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                err_cnt[g] <= 16'h0000;
            else if (wr && paddr == OFF_ERR)
                err_cnt[g] <= {15'h0000, err_inc};
            else if (err_inc && err_cnt[g] != HLS_ERR_MAX)
                err_cnt[g] <= err_cnt[g] + 16'h0001; // [R9]
        end

        assign ev[g*HLS_EV_W +: HLS_EV_W] = {rx_ovr, rx_ferr, rx_perr, tx_done, rx_store};
        assign live[g] = {2'h0, fdx, rx_busy, paused, rx_full, tx_state == HLS_TX_SHIFT,
            tx_full};
    end
endmodule : hls_host_link_serial_port

// ### hls_host_link_serial_port_checker.sv
// Assertions on the ports of the host link serial port.
`timescale 1ns/10ps
module hls_checker
    import hls_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [HLS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic txd_p1,
    input wire logic txd_p2,
    input wire logic full_duplex_p1,
    input wire logic full_duplex_p2,
    input wire logic line_rs422_p2,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    assign wr = psel && penable && pready && pwrite;
    a_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error with data");
    a_unmapped_err: assert property (psel && penable && pready && paddr > HLS_LIVE |-> pslverr)
        else $error("unmapped address accepted");
    a_mask_quiet: assert property (wr && paddr == HLS_MASK && pwdata[9:0] == 10'h0 |-> ##2 !irq)
        else $error("irq while masked");
    a_idle_reset: assert property ($rose(presetn) |-> txd_p1 && txd_p2 && !irq)
        else $error("lines not idle after reset");
    a_bit_low: assert property ($fell(txd_p1) |-> !txd_p1 [*8])
        else $error("short space bit");
    a_bit_high: assert property ($rose(txd_p1) |-> txd_p1 [*8])
        else $error("short mark bit");
    a_cfg_duplex1: assert property (wr && paddr == HLS_CFG0
        |-> ##3 full_duplex_p1 == $past(pwdata[HLS_CFG_FDX], 3))
        else $error("port 1 duplex wrong");
    a_cfg_line2: assert property (wr && paddr == HLS_CFG1
        |-> ##3 line_rs422_p2 == $past(pwdata[9], 3)
        && full_duplex_p2 == ($past(pwdata[9], 3) | $past(pwdata[0], 3)))
        else $error("port 2 line mode wrong");
endmodule : hls_checker

bind hls_host_link_serial_port hls_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .txd_p1, .txd_p2, .full_duplex_p1,
    .full_duplex_p2, .line_rs422_p2, .irq);

// ### hls_host_model.sv
// Host computer model for one serial port: frame sampler and sender.
`timescale 1ns/10ps
module hls_host_model
(
    input wire logic pclk,
    input wire logic txd,
    output logic rxd
);
    int bit_cyc = 64;
    int nb = 10;
    int nrx = 0;
    logic [11:0] frame;
    initial rxd = 1'h1;
    // Samples every bit at its middle, using the same rate and length as the device.
    always
    begin
        @(negedge txd);
        repeat (bit_cyc / 2) @(posedge pclk);
        for (int i = 0; i < nb; i++)
        begin
            repeat (bit_cyc) @(posedge pclk);
            frame[i] = txd;
        end
        nrx++;
    end
    // Sends a start bit, then the given bits LSB first, then returns to mark.
    task send(input logic [11:0] b, input int n);
        rxd <= 1'h0;
        repeat (bit_cyc) @(posedge pclk);
        for (int i = 0; i < n; i++)
        begin
            rxd <= b[i];
            repeat (bit_cyc) @(posedge pclk);
        end
        rxd <= 1'h1;
    endtask : send
endmodule : hls_host_model

// ### hls_host_link_serial_port_test.sv
// Self-checking testbench of the host link serial port.
`timescale 1ns/10ps
module hls_host_link_serial_port_test
    import hls_pkg::*;
;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, v;
    logic pready, pslverr, e, rxd_p1, txd_p1, txd_p2, full_duplex_p1, full_duplex_p2;
    logic line_rs422_p2, irq;
    int failures = 0;
    int total_checks = 0;
    int seed = 61;
    int cyc = 0;
    hls_host_link_serial_port #(.CLK_HZ(614400)) dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd_p1, .rxd_p2(1'h1), .txd_p1,
        .txd_p2, .full_duplex_p1, .full_duplex_p2, .line_rs422_p2, .irq);
    hls_host_model h1 (.pclk, .txd(txd_p1), .rxd(rxd_p1));
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            failures++;
            end_sim();
        end
    end
    task end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        v = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task rchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(v, x);
    endtask : rchk
    task poll(input logic [7:0] a, input int b);
        do
            apb(1'h0, a, 32'h0);
        while (v[b] !== 1'h1);
    endtask : poll
    // Expected bits after the start bit: data, parity if on, then mark.
    function automatic logic [11:0] frm(input logic [7:0] d, input logic [9:0] c);
        logic [11:0] f;
        f = {4'hf, d};
        if (!c[5])
            f[7] = 1'h1;
        if (c[7] ^ c[6])
            f[c[5] ? 8 : 7] = ^d ^ c[7];
        return f;
    endfunction : frm
    initial
    begin
        logic [9:0] c;
        logic [7:0] d, x;
        logic [31:0] mk;
        int k, m;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        rchk(HLS_CFG0, 32'h4c);
        rchk(HLS_CFG1, 32'h4c);
        apb(1'h0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'h1, HLS_CFG0, 32'h3ff);
        rchk(HLS_CFG0, 32'h1ff);
        chk({31'h0, full_duplex_p1}, 32'h1);
        for (k = 0; k < 3; k++)
        begin
            c = k == 0 ? 10'h24c : (k == 1 ? 10'h04c : 10'h04d);
            apb(1'h1, HLS_CFG1, {22'h0, c});
            repeat (2) @(posedge pclk);
            chk({30'h0, line_rs422_p2, full_duplex_p2}, {30'h0, c[9], c[9] | c[0]});
        end
        $display("config test done");
        apb(1'h1, HLS_FCHK0, 32'h0);
        apb(1'h1, HLS_MASK, 32'h2);
        x = 8'h0;
        for (k = 0; k < 9; k++)
        begin
            c = 10'($random(seed));
            c[4:2] = k < 5 ? k[2:0] : 3'h4;
            d = 8'($random(seed));
            d[7] = d[7] & c[5];
            h1.bit_cyc = 512 >> (k < 5 ? k : 4);
            h1.nb = 8 + c[5] + (c[7] ^ c[6]) + c[1];
            mk = (32'h1 << h1.nb) - 32'h1;
            apb(1'h1, HLS_CFG0, {22'h0, c});
            m = h1.nrx;
            apb(1'h1, HLS_TX0, {24'h0, d});
            x = x ^ d;
            while (h1.nrx == m) @(posedge pclk);
            chk({20'h0, h1.frame} & mk, {20'h0, frm(d, c)} & mk);
            poll(HLS_STAT, HLS_EV_TXDONE);
            @(posedge pclk);
            chk({31'h0, irq}, 32'h1);
            apb(1'h1, HLS_STAT, 32'h2);
            rchk(HLS_STAT, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        rchk(HLS_FCHK0, {24'h0, x});
        apb(1'h1, HLS_MASK, 32'h0);
        $display("transmit test done");
        c = 10'h16d;
        apb(1'h1, HLS_CFG0, {22'h0, c});
        apb(1'h1, HLS_ERR0, 32'h0);
        h1.bit_cyc = 64;
        h1.nb = 10;
        for (k = 0; k < 3; k++)
        begin
            d = {1'h1, 7'($random(seed))};
            h1.send(frm(d, c) ^ (k == 2 ? 12'h100 : 12'h0), 10);
            poll(HLS_STAT, k == 2 ? HLS_EV_PAR : HLS_EV_RX);
            apb(1'h0, HLS_RX0, 32'h0);
            if (k < 2)
                chk(v, {24'h0, d});
            apb(1'h1, HLS_STAT, 32'h3ff);
        end
        rchk(HLS_ERR0, 32'h1);
        m = h1.nrx;
        fork
            h1.send(frm(HLS_XOFF, c), 10);
            begin
                repeat (320) @(posedge pclk);
                apb(1'h1, HLS_TX0, 32'h41);
            end
        join
        while (h1.nrx == m) @(posedge pclk);
        chk({20'h0, h1.frame} & 32'h3ff, {20'h0, frm(8'h41, c)} & 32'h3ff);
        poll(HLS_LIVE, 3);
        apb(1'h1, HLS_TX0, 32'h42);
        repeat (1500) @(posedge pclk);
        chk(h1.nrx - m, 32'h1);
        h1.send(frm(HLS_XON, c), 10);
        while (h1.nrx == m + 1) @(posedge pclk);
        chk({20'h0, h1.frame} & 32'h3ff, {20'h0, frm(8'h42, c)} & 32'h3ff);
        $display("receive and flow test done");
        end_sim();
    end
endmodule : hls_host_link_serial_port_test
